// File: shared/lpsr_pkg.sv
package lpsr_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int CLK_PERIOD_NS = 20;
   // device timing figures, ns
   localparam int INDEX_TO_DATA_TIME_NS = 25;
   localparam int SELECT_TO_DATA_TIME_NS = 25;
   localparam int DRIVE_TO_DATA_TIME_NS = 10;
   localparam int MIN_READ_CYCLE_TIME_NS = 25;
   localparam int ADDR_SETTLE_NS = 0;
   // least times round up to whole cycles, never below one
   function automatic int lpsr_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int INDEX_CYC = lpsr_cycles(INDEX_TO_DATA_TIME_NS);
   localparam int SELECT_CYC = lpsr_cycles(SELECT_TO_DATA_TIME_NS);
   localparam int DRIVE_CYC = lpsr_cycles(DRIVE_TO_DATA_TIME_NS);
   localparam int CYCLE_CYC = lpsr_cycles(MIN_READ_CYCLE_TIME_NS);
   localparam int SETTLE_CYC = lpsr_cycles(ADDR_SETTLE_NS);
   localparam int CNT_W = 4;
   typedef logic [ADDR_W-1:0] lpsr_addr_t;
   typedef logic [DATA_W-1:0] lpsr_data_t;
   typedef logic [CNT_W-1:0] lpsr_cnt_t;
   typedef enum logic [4:0] {
      LPSR_IDLE   = 5'h01,
      LPSR_SETTLE = 5'h02,
      LPSR_SELECT = 5'h04,
      LPSR_DRIVE  = 5'h08,
      LPSR_HOLD   = 5'h10
   } lpsr_state_e;
endpackage

// File: design/lpsr_wait_timer.sv
`timescale 1ns/100ps
module lpsr_wait_timer (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // control
   input  wire logic              load,
   input  wire lpsr_pkg::lpsr_cnt_t loadValue,
   // status
   output logic                   done
);
   import lpsr_pkg::*;
   lpsr_cnt_t countQ;
   assign done = (countQ == '0);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         countQ <= '0;
      end else if (load) begin
         countQ <= loadValue;
      end else if (!done) begin
         countQ <= countQ - 4'h1;
      end
   end
endmodule

// File: design/lpsr_read_host.sv
// Behaviour
// R01: device senses only on a new read request, never continuously.
// R02: select assertion or index change while selected requests a read.
// R03: simultaneous triggers merge into one sense operation.
// R04: device senses for about five nanoseconds per request.
// R05: index change while selected and driving gives data after index access time.
// R06: data stays driven through the cycle while select and drive stay active.
// R07: host changes index at most once per minimum read cycle.
// R08: select going active starts read; data after select access time.
// R09: host holds index stable, drive on, write off, through select read.
// R10: index settled no later than the select edge.
// R11: drive-controlled data after drive time, or later access time if pending.
// R12: drive-controlled read shows data already sensed by prior access.
// R13: merged trigger lasts only the first four to five nanoseconds.
// R14: skew beyond four to five nanoseconds starts another read.
// R15: no resensing without a new trigger; stale data persists.
// R16: host keeps skew among simultaneous switching inputs below four nanoseconds.
// R17: host uses one read access method at a time.
// R18: host delays select until all index lines finished changing.
// R19: data lines float when deselected, drive off, or writing.
`timescale 1ns/100ps
module lpsr_read_host (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // user request
   input  wire logic                 reqValid,
   input  wire lpsr_pkg::lpsr_addr_t reqAddr,
   output logic                      reqReady,
   // user answer
   output logic                      rspValid,
   output lpsr_pkg::lpsr_data_t      rspData,
   // memory pins
   output lpsr_pkg::lpsr_addr_t      memIndex,
   output logic                      selectActiveLow,
   output logic                      selectActiveHigh,
   output logic                      driveEnableN,
   output logic                      writeEnableN,
   output lpsr_pkg::lpsr_data_t      dataOut,
   output logic                      dataOeN,
   input  wire lpsr_pkg::lpsr_data_t dataIn
);
   import lpsr_pkg::*;

   lpsr_state_e stateQ, stateD;
   lpsr_addr_t  indexQ;
   lpsr_data_t  dataSync1Q, dataSync2Q, rspDataQ;
   logic        selQ, selLowQ, driveNQ, rspValidQ, readyQ;
   logic        timerLoad, timerDone;
   lpsr_cnt_t   timerValue;

   wire takeReq   = (stateQ == LPSR_IDLE) && reqValid;
   // a following read while still selected is an index access on the open select
   wire indexMode = takeReq && selQ;
   wire selMode   = takeReq && !selQ;
   wire toSelect  = (stateQ == LPSR_SETTLE) && timerDone;
   wire toDrive   = (stateQ == LPSR_SELECT) && timerDone;
   wire toHold    = (stateQ == LPSR_DRIVE) && timerDone;
   wire cycleDone = (stateQ == LPSR_HOLD) && timerDone;

   lpsr_wait_timer uTimer (
      .clk       (clk),
      .rst       (rst),
      .load      (timerLoad),
      .loadValue (timerValue),
      .done      (timerDone)
   );

   assign timerLoad = takeReq || toSelect || toDrive || toHold;
   // the index access time covers the later of access and drive times
   assign timerValue = selMode  ? lpsr_cnt_t'(SETTLE_CYC) :               // see R10 see R18
                       indexMode ? lpsr_cnt_t'(INDEX_CYC + 1) :           // see R05 see R11
                       toSelect ? lpsr_cnt_t'(SELECT_CYC) :                // see R08
                       toDrive  ? lpsr_cnt_t'(DRIVE_CYC + 1) :             // see R11 see R12
                       lpsr_cnt_t'(CYCLE_CYC);                             // see R07

   always_comb begin
      stateD = stateQ;
      case (stateQ)
         LPSR_IDLE:   if (selMode) stateD = LPSR_SETTLE;
                      else if (indexMode) stateD = LPSR_DRIVE;
         LPSR_SETTLE: if (timerDone) stateD = LPSR_SELECT;
         LPSR_SELECT: if (timerDone) stateD = LPSR_DRIVE;
         LPSR_DRIVE:  if (timerDone) stateD = LPSR_HOLD;
         LPSR_HOLD:   if (timerDone) stateD = LPSR_IDLE;
         default:     stateD = LPSR_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stateQ <= LPSR_IDLE;
      end else begin
         stateQ <= stateD;
      end
   end

   // index only moves when a request is taken, with select held or still off
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         indexQ <= '0;
      end else if (takeReq) begin
         indexQ <= reqAddr;                                                // see R09 see R17
      end
   end

   // select rises only after the index has settled; it stays on between reads
   // each pin level has its own flop so the pins never pass through logic
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         selQ    <= 1'b0;
         selLowQ <= 1'b1;
         driveNQ <= 1'b1;
      end else begin
         if (toSelect) selQ <= 1'b1;                                       // see R18 see R16
         if (toSelect) selLowQ <= 1'b0;                                    // see R18
         if (toSelect || indexMode) driveNQ <= 1'b0;                       // see R06
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dataSync1Q <= '0;
         dataSync2Q <= '0;
      end else begin
         dataSync1Q <= dataIn;
         dataSync2Q <= dataSync1Q;
      end
   end

   // capture once access time plus synchroniser delay has passed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rspDataQ  <= '0;
         rspValidQ <= 1'b0;
         readyQ    <= 1'b0;
      end else begin
         rspValidQ <= toHold;
         readyQ    <= (stateD == LPSR_IDLE);
         if (toHold) rspDataQ <= dataSync2Q;
      end
   end

   assign memIndex         = indexQ;
   assign selectActiveLow  = selLowQ;
   assign selectActiveHigh = selQ;
   assign driveEnableN     = driveNQ;
   assign writeEnableN     = 1'b1;     // read-only host; never writes
   assign dataOut          = '0;
   assign dataOeN          = 1'b1;     // host never drives data lines, see R19
   assign reqReady         = readyQ;
   assign rspValid         = rspValidQ;
   assign rspData          = rspDataQ;

   int idleCnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) idleCnt <= 0;
      else if (memIndex != $past(memIndex)) idleCnt <= 0;
      else if (idleCnt < 100) idleCnt <= idleCnt + 1;
   end

   a_index_spacing: assert property (@(posedge clk) disable iff (rst) // see R07
      $changed(memIndex) |-> $past(idleCnt) + 1 >= CYCLE_CYC)
      else $error("index changed faster than min read cycle");
   a_index_before_select: assert property (@(posedge clk) disable iff (rst) // see R10
      $rose(selectActiveHigh) |-> $stable(memIndex))
      else $error("index moved at select edge");
   a_one_method: assert property (@(posedge clk) disable iff (rst) // see R17
      $fell(selectActiveLow) |-> !$changed(memIndex))
      else $error("select and index switched together");
   a_select_stable: assert property (@(posedge clk) disable iff (rst) // see R09
      (stateQ == LPSR_SELECT) |-> $stable(memIndex) && writeEnableN)
      else $error("index not stable during select read");
   a_pins_paired: assert property (@(posedge clk) disable iff (rst) // see R16
      selectActiveLow != selectActiveHigh)
      else $error("select pins disagree");
   a_never_write: assert property (@(posedge clk) disable iff (rst) // see R19
      writeEnableN && dataOeN)
      else $error("host drove data or write");
   a_answer_time: assert property (@(posedge clk) disable iff (rst) // see R05
      (stateQ == LPSR_IDLE && reqValid && selectActiveHigh) |-> ##5 rspValid)
      else $error("index read answer late");
   a_skew_none: assert property (@(posedge clk) disable iff (rst) // see R16
      $rose(selectActiveHigh) |-> $past(stateQ) == LPSR_SETTLE)
      else $error("select raised without settle");
   c_first_read: cover property (@(posedge clk) $rose(selectActiveHigh) ##[1:8] rspValid);
   c_index_read: cover property (@(posedge clk) $changed(memIndex) && selectActiveHigh);
   c_back_to_back: cover property (@(posedge clk) rspValid ##[1:8] rspValid);
endmodule

// File: verification/lpsr_sram_model.sv
`timescale 1ns/100ps
module lpsr_sram_model (
   // memory pins
   input  wire lpsr_pkg::lpsr_addr_t memIndex,
   input  wire logic                 selectActiveLow,
   input  wire logic                 selectActiveHigh,
   input  wire logic                 driveEnableN,
   input  wire logic                 writeEnableN,
   output lpsr_pkg::lpsr_data_t      dataIn,
   // observation
   output int                        trigCount,
   output int                        hostFaults
);
   import lpsr_pkg::*;
   logic       sel;
   logic       validQ = 1'b0;
   logic       driveOn = 1'b0;
   lpsr_data_t sensedQ = 8'h00;
   realtime    tIdx = -1000.0;
   realtime    tTrig = -1000.0;
   int         seq = 0;
   initial trigCount = 0;
   initial hostFaults = 0;
   assign sel = !selectActiveLow && selectActiveHigh;
   // the array is sensed once per trigger and never while idle
   task automatic trig(input int acc);
      int s;
      if ($realtime - tTrig < 4.0) return;
      tTrig = $realtime;
      trigCount++;
      seq++;
      s = seq;
      validQ = 1'b0;
      sensedQ = memIndex[7:0] ^ memIndex[15:8] ^ {5'h00, memIndex[18:16]};
      if (writeEnableN !== 1'b1) hostFaults++;
      fork
         #(acc) if (s == seq) validQ = 1'b1;
      join_none
   endtask
   always @(posedge sel) begin
      if ($realtime - tIdx < ADDR_SETTLE_NS + 4.0) hostFaults++;
      trig(SELECT_TO_DATA_TIME_NS);
   end
   always @(memIndex) begin
      if (sel && $realtime - tIdx < MIN_READ_CYCLE_TIME_NS) hostFaults++;
      tIdx = $realtime;
      if (sel) trig(INDEX_TO_DATA_TIME_NS);
   end
   always @(driveEnableN) driveOn <= #(DRIVE_TO_DATA_TIME_NS) !driveEnableN;
   // released lines show the inverse so a late sample cannot pass
   assign dataIn = (sel && driveOn && writeEnableN && validQ) ? sensedQ : ~sensedQ;
endmodule

// File: verification/testbench.sv
`timescale 1ns/100ps
module testbench;
   import lpsr_pkg::*;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       reqValid = 1'b0;
   lpsr_addr_t reqAddr = 19'h00000;
   logic       reqReady, rspValid, selectActiveLow, selectActiveHigh;
   logic       driveEnableN, writeEnableN, dataOeN;
   lpsr_data_t rspData, dataOut, dataIn;
   lpsr_addr_t memIndex;
   int         trigCount, hostFaults;
   int         miscompares = 0;
   int         check_count = 0;
   always #(CLK_PERIOD_NS / 2) clk = ~clk;
   lpsr_read_host i_lpsr_read_host (.clk(clk), .rst(rst), .reqValid(reqValid),
      .reqAddr(reqAddr), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
      .memIndex(memIndex), .selectActiveLow(selectActiveLow),
      .selectActiveHigh(selectActiveHigh), .driveEnableN(driveEnableN),
      .writeEnableN(writeEnableN), .dataOut(dataOut), .dataOeN(dataOeN), .dataIn(dataIn));
   lpsr_sram_model i_lpsr_sram_model (.memIndex(memIndex), .selectActiveLow(selectActiveLow),
      .selectActiveHigh(selectActiveHigh), .driveEnableN(driveEnableN),
      .writeEnableN(writeEnableN), .dataIn(dataIn), .trigCount(trigCount),
      .hostFaults(hostFaults));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // one read; trigs is how many senses the device should see for it
   task automatic rd(input lpsr_addr_t a, input int trigs);
      int n;
      int t0;
      n = 0;
      t0 = trigCount;
      while (reqReady !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      reqValid <= 1'b1;
      reqAddr <= a;
      @(posedge clk);
      reqValid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rspValid !== 1'b1 && n < 20);
      chk(rspValid, 1'b1);
      chk(rspData, a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]});
      chk(trigCount - t0, trigs);
   endtask
   task automatic t_select_read();
      rd(19'h12345, 1);
      chk({selectActiveLow, selectActiveHigh, driveEnableN}, 3'b010);
   endtask
   task automatic t_index_reads();
      lpsr_addr_t tbl[5] = '{19'h00000, 19'h7ffff, 19'h7ffff, 19'h00001, 19'h40000};
      lpsr_addr_t prev;
      prev = 19'h12345;
      foreach (tbl[i]) begin
         rd(tbl[i], (tbl[i] != prev) ? 1 : 0);
         prev = tbl[i];
      end
   endtask
   // abort a read by reset, then the next read must be select-controlled again
   task automatic t_reset_mid();
      repeat (4) @(posedge clk);
      reqValid <= 1'b1;
      reqAddr <= 19'h2abcd;
      // reset lands mid-read but a full read cycle after the index moved
      repeat (3) @(posedge clk);
      reqValid <= 1'b0;
      rst <= 1'b1;
      @(negedge clk);
      chk({reqReady, selectActiveLow, selectActiveHigh, driveEnableN}, 4'b0101);
      @(posedge clk);
      rst <= 1'b0;
      rd(19'h0abcd, 1);
   endtask
   always @(negedge clk) begin
      if (!rst) begin
         chk({writeEnableN, dataOeN}, 2'b11);
      end
   end
   initial begin
      #(CLK_PERIOD_NS * 5000);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_select_read();
      t_index_reads();
      t_reset_mid();
      chk(hostFaults, 0);
      tally_and_finish();
   end
endmodule
